// [hdl/drc_ctrl.sv]
// Refresh and access sequencer for a multiplexed-address DRAM controller.
// Assumes all inputs synchronous to clk_i; the strobe generator and refresh
// period clocks arrive as ordinary sampled inputs; the bus side keeps its own rules.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Two 9-bit address latches and a 9-bit refresh counter.
// - Eight operating modes selected on the mode pins.
// - Auto access: row strobe request fall starts row, switch, column strobe.
// - Chip select high cycle yields hidden refresh, done before next access.
// - Refresh slot opens on period clock rise; counter drives address.
// - Hidden refresh: all row strobes follow request; counter bumps on rise.
// - At most one hidden refresh per refresh period.
// - No hidden refresh by period clock fall: request pin goes low.
// - Second strobe-clock fall after ack: all row strobes low for two periods.
// - Forced refresh about four strobe-clock periods, one per period.
// - Auto access keeps 30 ns row hold and 8 ns column setup.
module drc_ctrl #(
   parameter int unsigned AW = drc_pkg::ADDR_W
) (
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic              clk_en_i,
   input  wire drc_pkg::drc_mode_t mode_i,
   input  wire logic              refresh_mode_select_n_i,
   input  wire logic              row_strobe_request_n_i,
   input  wire logic              cs_n_i,
   input  wire logic              refresh_period_clock_i,
   input  wire logic              strobe_generator_clock_i,
   input  wire logic              latch_en_i,
   input  wire logic [AW-1:0]     row_addr_i,
   input  wire logic [AW-1:0]     col_addr_i,
   input  wire logic [1:0]        bank_i,
   input  wire logic              write_n_i,
   output logic [3:0]             ras_n_o,
   output logic                   cas_n_o,
   output logic [AW-1:0]          addr_o,
   output logic                   we_n_o,
   output logic                   refresh_request_pin_n_o,
   output logic                   burst_done_o
);
   // Access and hidden refresh phases
   typedef enum logic [2:0] {
      DRC_IDLE, DRC_ROW, DRC_COL, DRC_CAS, DRC_HID
   } drc_acc_t;
   // Forced refresh phases
   typedef enum logic [1:0] {
      DRC_F_IDLE, DRC_F_WAIT, DRC_F_LOW, DRC_F_DONE
   } drc_frc_t;

   logic [AW-1:0] row_q, col_q, rfc_q, eoc_q;
   logic          rsr_q, rfk_q, sgk_q;
   logic          hid_done_q, frc_done_q;
   logic [1:0]    fall_cnt_q, low_cnt_q;
   logic [1:0]    dly_q;
   drc_acc_t      acc_q;
   drc_frc_t      frc_q;
   logic          rsr_fall, rsr_rise, rfk_rise, rfk_fall, sgk_fall;
   logic          refresh_mode, auto_mode, ext_access;

   // Bank decoder shared by access paths
   function automatic logic [3:0] bank_sel(input logic [1:0] b);
      bank_sel = 4'h1 << b;
   endfunction

   // Counter step with wrap at the programmed end of count
   function automatic logic [AW-1:0] rfc_next(input logic [AW-1:0] c,
                                              input logic [AW-1:0] e);
      rfc_next = (c == e) ? '0 : c + 1'b1;
   endfunction

   // Edges are taken against the last sample; request history resets high so
   // the first request after reset is seen and no false rise follows reset
   assign rsr_fall     = rsr_q && !row_strobe_request_n_i;
   assign rsr_rise     = !rsr_q && row_strobe_request_n_i;
   assign rfk_rise     = !rfk_q && refresh_period_clock_i;
   assign rfk_fall     = rfk_q && !refresh_period_clock_i;
   assign sgk_fall     = sgk_q && !strobe_generator_clock_i;
   assign auto_mode    = (mode_i == drc_pkg::DRC_M_AUTO_ACCESS) ||
                         (mode_i == drc_pkg::DRC_M_FAST_ACCESS);
   assign ext_access   = (mode_i == drc_pkg::DRC_M_EXT_ACCESS) ||
                         (mode_i == drc_pkg::DRC_M_ALL_WRITE);
   // Mode select low acts as forced-refresh acknowledge
   assign refresh_mode = !refresh_mode_select_n_i;

   // Edge history of the sampled clocks and request
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rsr_q <= 1'b1;
         rfk_q <= 1'b0;
         sgk_q <= 1'b0;
      end else if (clk_en_i) begin
         rsr_q <= row_strobe_request_n_i;
         rfk_q <= refresh_period_clock_i;
         sgk_q <= strobe_generator_clock_i;
      end
   end

   // Row and column address latches; registered, loading each clock while latch enable high
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         row_q <= '0;
         col_q <= '0;
      end else if (clk_en_i && latch_en_i) begin
         row_q <= row_addr_i;
         col_q <= col_addr_i;
      end
   end

   // End-of-count register loaded from row address in set mode
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         eoc_q <= AW'(drc_pkg::EOC_RESET);
      end else if (clk_en_i && mode_i == drc_pkg::DRC_M_SET_EOC && rsr_fall) begin
         eoc_q <= row_addr_i;
      end
   end

   // Refresh slot bookkeeping: one hidden or one forced per period
   // A slot boundary clears both flags; a refresh ending on it counts for the old slot
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         hid_done_q <= 1'b0;
         frc_done_q <= 1'b0;
         refresh_request_pin_n_o <= 1'b1;
      end else if (clk_en_i) begin
         if (rfk_rise) begin
            hid_done_q <= 1'b0;
            frc_done_q <= 1'b0;
         end else begin
            if (acc_q == DRC_HID && rsr_rise)
               hid_done_q <= 1'b1;
            if (frc_q == DRC_F_DONE)
               frc_done_q <= 1'b1;
         end
         // Request drops on period fall when nothing refreshed in the slot
         if (rfk_fall && !hid_done_q && !(acc_q == DRC_HID) && !frc_done_q)
            refresh_request_pin_n_o <= 1'b0;
         else if (frc_q == DRC_F_LOW || rfk_rise)
            refresh_request_pin_n_o <= 1'b1;
      end
   end

   // Access / hidden refresh sequencer driven by the row strobe request
   // Fast access shares the slow timing: one clock already covers both holds
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         acc_q <= DRC_IDLE;
         dly_q <= '0;
      end else if (clk_en_i) begin
         case (acc_q)
            DRC_IDLE: begin
               dly_q <= '0;
               if (rsr_fall && !refresh_mode) begin
                  // Chip select high during the slot means hidden refresh
                  if (cs_n_i && refresh_period_clock_i && !hid_done_q && !frc_done_q)
                     acc_q <= DRC_HID;
                  else if (!cs_n_i && (auto_mode || ext_access))
                     acc_q <= DRC_ROW;
               end
            end
            DRC_ROW: begin
               // Row address held long enough past row strobe fall
               dly_q <= dly_q + 2'h1;
               if (row_strobe_request_n_i)
                  acc_q <= DRC_IDLE;
               else if (32'(dly_q) + 1 >= drc_pkg::ROW_HOLD_CYC)
                  acc_q <= DRC_COL;
            end
            DRC_COL: begin
               dly_q <= '0;
               if (row_strobe_request_n_i)
                  acc_q <= DRC_IDLE;
               else if (drc_pkg::COL_SETUP_CYC <= 1)
                  acc_q <= DRC_CAS;
            end
            DRC_CAS: begin
               if (row_strobe_request_n_i)
                  acc_q <= DRC_IDLE;
            end
            DRC_HID: begin
               // Finishes with the request so the next access is not delayed
               if (row_strobe_request_n_i)
                  acc_q <= DRC_IDLE;
            end
            default: acc_q <= DRC_IDLE;
         endcase
      end
   end

   // Forced refresh timed on strobe generator falls
   // Each fall needs two samples of the strobe clock, so it must run no faster than half rate
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         frc_q      <= DRC_F_IDLE;
         fall_cnt_q <= '0;
         low_cnt_q  <= '0;
      end else if (clk_en_i) begin
         case (frc_q)
            DRC_F_IDLE: begin
               fall_cnt_q <= '0;
               low_cnt_q  <= '0;
               // Mode select low turns auto access into auto forced refresh
               if (refresh_mode && !refresh_request_pin_n_o &&
                   (mode_i == drc_pkg::DRC_M_AUTO_FORCED ||
                    mode_i == drc_pkg::DRC_M_AUTO_ACCESS)) begin
                  frc_q <= DRC_F_WAIT;
                  // A strobe-clock fall seen together with the acknowledge is the first
                  if (sgk_fall)
                     fall_cnt_q <= 2'h1;
               end
            end
            DRC_F_WAIT: begin
               if (sgk_fall) begin
                  fall_cnt_q <= fall_cnt_q + 2'h1;
                  if (32'(fall_cnt_q) + 1 >= drc_pkg::FRC_WAIT_FALLS)
                     frc_q <= DRC_F_LOW;
               end
            end
            DRC_F_LOW: begin
               // Strobes stay low two periods even if mode select rises early
               if (sgk_fall) begin
                  low_cnt_q <= low_cnt_q + 2'h1;
                  if (32'(low_cnt_q) + 1 >= drc_pkg::FRC_LOW_PER)
                     frc_q <= DRC_F_DONE;
               end
            end
            DRC_F_DONE: begin
               if (!refresh_mode)
                  frc_q <= DRC_F_IDLE;
            end
            default: frc_q <= DRC_F_IDLE;
         endcase
      end
   end

   // Refresh counter: bumps after hidden, forced or external refresh
   // The forced bump lands on the last strobe-clock fall of the low phase
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rfc_q        <= AW'(drc_pkg::RFC_RESET);
         burst_done_o <= 1'b0;
      end else if (clk_en_i) begin
         if ((acc_q == DRC_HID && rsr_rise) ||
             (frc_q == DRC_F_LOW && sgk_fall && 32'(low_cnt_q) + 1 >= drc_pkg::FRC_LOW_PER) ||
             (refresh_mode && rsr_rise &&
              (mode_i == drc_pkg::DRC_M_EXT_REFRESH || mode_i == drc_pkg::DRC_M_BURST)))
            rfc_q <= rfc_next(rfc_q, eoc_q);
         if (mode_i == drc_pkg::DRC_M_BURST && refresh_mode && rsr_rise)
            burst_done_o <= (rfc_q == eoc_q);
         else if (!refresh_mode)
            burst_done_o <= 1'b0;
      end
   end

   // DRAM pin drivers, all registered
   // Priority: forced refresh, hidden or external refresh, slot address, access
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ras_n_o <= 4'hF;
         cas_n_o <= 1'b1;
         addr_o  <= '0;
         we_n_o  <= 1'b1;
      end else if (clk_en_i) begin
         ras_n_o <= 4'hF;
         cas_n_o <= 1'b1;
         we_n_o  <= 1'b1;
         addr_o  <= row_q;
         if (frc_q == DRC_F_LOW) begin
            ras_n_o <= 4'h0;
            addr_o  <= rfc_q;
         end else if (acc_q == DRC_HID ||
                      (refresh_mode && (mode_i == drc_pkg::DRC_M_EXT_REFRESH ||
                                        mode_i == drc_pkg::DRC_M_BURST))) begin
            ras_n_o <= {4{row_strobe_request_n_i}};
            addr_o  <= rfc_q;
         end else if (cs_n_i && refresh_period_clock_i && !hid_done_q) begin
            addr_o  <= rfc_q;
         end else if (acc_q != DRC_IDLE) begin
            ras_n_o <= (mode_i == drc_pkg::DRC_M_ALL_WRITE) ? 4'h0 : ~bank_sel(bank_i);
            addr_o  <= (acc_q == DRC_ROW) ? row_q : col_q;
            cas_n_o <= !(acc_q == DRC_CAS);
            we_n_o  <= write_n_i;
         end
      end
   end
endmodule // drc_ctrl

`default_nettype wire

// [hdl/drc_pkg.sv]
// Package for the refresh and access sequencer of the multiplexed DRAM controller.
// Assumes a single 25 MHz system clock; all pins sampled synchronously.
package drc_pkg;
   localparam int unsigned ADDR_W         = 9;
   localparam int unsigned BANKS          = 4;
   localparam int unsigned CLK_PERIOD_NS  = 40;
   // Row address hold and column setup, least times in ns
   localparam int unsigned ROW_HOLD_NS    = 30;
   localparam int unsigned COL_SETUP_NS   = 8;
   localparam int unsigned ROW_HOLD_CYC   =
      (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned COL_SETUP_CYC  =
      (COL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Forced refresh: strobes fall on second strobe-clock fall, low for two periods
   localparam int unsigned FRC_WAIT_FALLS = 2;
   localparam int unsigned FRC_LOW_PER    = 2;
   localparam logic [8:0]  RFC_RESET      = 9'h000;
   localparam logic [8:0]  EOC_RESET      = 9'h1FF;

   // Operating modes, encoded on the three mode pins
   typedef enum logic [2:0] {
      DRC_M_EXT_REFRESH  = 3'h0,
      DRC_M_AUTO_FORCED  = 3'h1,
      DRC_M_BURST        = 3'h2,
      DRC_M_ALL_WRITE    = 3'h3,
      DRC_M_EXT_ACCESS   = 3'h4,
      DRC_M_AUTO_ACCESS  = 3'h5,
      DRC_M_FAST_ACCESS  = 3'h6,
      DRC_M_SET_EOC      = 3'h7
   } drc_mode_t;

   // DRAM-side strobes and address
   typedef struct packed {
      logic [3:0] ras_n;
      logic       cas_n;
      logic [8:0] addr;
   } drc_dram_t;
endpackage

// [tb/drc_ctrl_assertions.sv]
// Checker for the DRAM sequencer, on the top module's ports.
// Assumes clk_en_i high and auto access mode traffic.
`timescale 1ns/1ns
`default_nettype none
module drc_ctrl_chk (
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic       refresh_mode_select_n_i,
   input wire logic       row_strobe_request_n_i,
   input wire logic       cs_n_i,
   input wire logic       refresh_period_clock_i,
   input wire logic       strobe_generator_clock_i,
   input wire logic [1:0] bank_i,
   input wire logic [3:0] ras_n_o,
   input wire logic       cas_n_o,
   input wire logic [8:0] addr_o,
   input wire logic       refresh_request_pin_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [8:0] cnt_q;
   logic [3:0] ras_q;
   logic [1:0] fall_q;
   logic       used_q;
   // Shadow count and slot use; a forced refresh spends the slot too
   always_ff @(posedge clk_i) begin
      ras_q <= ras_n_o;
      if (!resetn_i) begin
         cnt_q <= 9'h000;
         used_q <= 1'b0;
         fall_q <= 2'h0;
      end else begin
         if (ras_q == 4'h0 && ras_n_o == 4'hF) cnt_q <= cnt_q + 9'h001;
         if ($rose(refresh_period_clock_i)) used_q <= 1'b0;
         else if (ras_n_o == 4'h0) used_q <= 1'b1;
         if (refresh_mode_select_n_i) fall_q <= 2'h0;
         else if ($fell(strobe_generator_clock_i) && fall_q != 2'h3) fall_q <= fall_q + 2'h1;
      end
   end
   sequence acc_s;
      $fell(row_strobe_request_n_i) && !cs_n_i && refresh_mode_select_n_i;
   endsequence
   sequence hid_s;
      $fell(row_strobe_request_n_i) && cs_n_i && refresh_period_clock_i && refresh_mode_select_n_i;
   endsequence
   access_row_a: assert property (acc_s |-> ##[1:3] ras_n_o == ~(4'h1 << bank_i))
      else $error("access strobe wrong");
   row_hold_a: assert property ($fell(cas_n_o) |-> $past(ras_n_o, 2) != 4'hF)
      else $error("row hold short");
   col_setup_a: assert property ($fell(cas_n_o) |-> $stable(addr_o))
      else $error("column setup short");
   strobe_release_a: assert property ($rose(row_strobe_request_n_i) &&
      refresh_mode_select_n_i |-> ##[1:2] ras_n_o == 4'hF && cas_n_o)
      else $error("strobes not released");
   hidden_refresh_a: assert property ((hid_s and !used_q)
      |-> ##[1:3] ras_n_o == 4'h0 && addr_o == cnt_q)
      else $error("hidden refresh wrong");
   one_hidden_a: assert property ((hid_s and used_q)
      |-> ##1 (ras_n_o == 4'hF) [*3])
      else $error("second refresh in slot");
   refresh_request_a: assert property ($fell(refresh_period_clock_i) && !used_q
      |-> ##[1:2] !refresh_request_pin_n_o)
      else $error("request pin not low");
   no_request_a: assert property ($fell(refresh_period_clock_i) && used_q
      |-> ##1 refresh_request_pin_n_o [*3])
      else $error("needless request");
   forced_ras_a: assert property ($fell(strobe_generator_clock_i) &&
      fall_q == 2'h1 && !refresh_mode_select_n_i |-> ##[1:2] ras_n_o == 4'h0)
      else $error("forced strobes late");
   forced_hold_a: assert property ($fell(strobe_generator_clock_i) &&
      fall_q == 2'h2 && !refresh_mode_select_n_i |=> ras_n_o == 4'h0)
      else $error("forced strobes short");
endmodule // drc_ctrl_chk
bind drc_ctrl drc_ctrl_chk u_chk (
   .clk_i(clk_i), .resetn_i(resetn_i), .refresh_mode_select_n_i(refresh_mode_select_n_i),
   .row_strobe_request_n_i(row_strobe_request_n_i), .cs_n_i(cs_n_i),
   .refresh_period_clock_i(refresh_period_clock_i), .bank_i(bank_i),
   .strobe_generator_clock_i(strobe_generator_clock_i), .ras_n_o(ras_n_o),
   .cas_n_o(cas_n_o), .addr_o(addr_o), .refresh_request_pin_n_o(refresh_request_pin_n_o));
`default_nettype wire

// [tb/drc_glue_model.sv]
// Bus-side glue model: answers refresh requests with mode select.
// Assumes it sees the request pin and the row strobes.
`timescale 1ns/1ns
`default_nettype none
module drc_glue_model (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       refresh_request_pin_n_i,
   input  wire logic [3:0] ras_n_i,
   input  wire logic       cs_n_i,
   input  wire logic       wait_n_i,
   input  wire logic       write_n_i,
   output var  logic       cycle_a_n_o,
   output var  logic       refresh_mode_select_n_o
);
   logic sel_q;
   logic st1_q;
   logic st2_q;
   logic st3_q;
   // Sampled mid cycle; the chain waits for strobes low so release is safe
   always @(negedge clk_i) begin
      if (!resetn_i) begin
         {sel_q, st1_q, st2_q, st3_q} <= 4'h0;
      end else begin
         sel_q <= !refresh_request_pin_n_i || (sel_q && !st3_q);
         st1_q <= sel_q && (ras_n_i == 4'h0 || st1_q);
         st2_q <= st1_q;
         st3_q <= st2_q;
      end
   end
   assign refresh_mode_select_n_o = !sel_q;
   // Only DRAM cycles are held, until the second stage is set; other cycles run on
   assign cycle_a_n_o = !(!cs_n_i && ((sel_q && !st2_q) ||
                                      (!wait_n_i && write_n_i)));
endmodule // drc_glue_model
`default_nettype wire

// [tb/drc_ctrl_tb_top.sv]
// Bench for the DRAM sequencer: accesses, hidden and forced refresh.
// Assumes the glue model answers refresh requests.
`timescale 1ns/1ns
`default_nettype none
module drc_ctrl_tb_top;
   typedef struct packed {
      logic [1:0] bank;
      logic [8:0] row;
      logic [8:0] col;
      logic       wr_n;
      logic [3:0] ras;
   } drc_row_t;
   drc_row_t rows [4] = '{'{2'h0, 9'h000, 9'h1FF, 1'b1, 4'hE}, '{2'h1, 9'h1FF, 9'h000, 1'b0, 4'hD},
                         '{2'h2, 9'h155, 9'h0AA, 1'b1, 4'hB}, '{2'h3, 9'h0AA, 9'h155, 1'b0, 4'h7}};
   drc_pkg::drc_dram_t dram;
   logic       clk, rst_n, req_n, cs_n, refresh_period_clock, sgc, sel_n, wr_n, we_n, pin, burst;
   logic       wait_n, cycle_a_n;
   logic [1:0] bank;
   logic [8:0] row, col;
   int         err_count, compares, cyc, i;
   drc_ctrl dut (
      .clk_i(clk), .resetn_i(rst_n), .clk_en_i(1'b1), .mode_i(drc_pkg::DRC_M_AUTO_ACCESS),
      .refresh_mode_select_n_i(sel_n), .row_strobe_request_n_i(req_n), .cs_n_i(cs_n),
      .refresh_period_clock_i(refresh_period_clock), .strobe_generator_clock_i(sgc), .latch_en_i(1'b1),
      .row_addr_i(row), .col_addr_i(col), .bank_i(bank), .write_n_i(wr_n),
      .ras_n_o(dram.ras_n), .cas_n_o(dram.cas_n), .addr_o(dram.addr), .we_n_o(we_n),
      .refresh_request_pin_n_o(pin), .burst_done_o(burst));
   drc_glue_model u_glue (.clk_i(clk), .resetn_i(rst_n), .refresh_request_pin_n_i(pin),
      .ras_n_i(dram.ras_n), .cs_n_i(cs_n), .wait_n_i(wait_n), .write_n_i(wr_n),
      .cycle_a_n_o(cycle_a_n), .refresh_mode_select_n_o(sel_n));
   // Clock; the strobe clock runs free at half rate
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Cycle ceiling cuts a hang short
   always @(negedge clk) begin
      sgc <= ~sgc;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Select a clock ahead of the request, hold it to the end of the cycle
   task automatic access(input drc_row_t r);
      {bank, row, col, wr_n} = {r.bank, r.row, r.col, r.wr_n};
      cs_n = 1'b0;
      @(negedge clk);
      req_n = 1'b0;
      for (i = 0; i < 8 && dram.ras_n === 4'hF; i++) @(negedge clk);
      chk(dram.ras_n, r.ras);
      chk(dram.addr, r.row);
      for (i = 0; i < 8 && dram.cas_n !== 1'b0; i++) @(negedge clk);
      chk(dram.addr, r.col);
      chk(we_n, r.wr_n);
      req_n = 1'b1;
      repeat (2) @(negedge clk);
      chk({dram.ras_n, dram.cas_n}, 5'h1F);
      cs_n = 1'b1;
      @(negedge clk);
   endtask
   task automatic hidden(input logic [8:0] cnt, input logic [3:0] ras);
      req_n = 1'b0;
      repeat (4) @(negedge clk);
      chk(dram.ras_n, ras);
      if (ras == 4'h0) chk(dram.addr, cnt);
      req_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   initial begin
      {rst_n, req_n, cs_n, refresh_period_clock, sgc, wr_n, wait_n} = 7'h33;
      {bank, row, col} = 20'h00000;
      {err_count, compares, cyc} = '0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk({dram.ras_n, dram.cas_n, pin, burst, dram.addr}, 16'hFC00);
      // Wait input on a DRAM read stretches the cycle by one state
      {cs_n, wait_n} = 2'h0;
      @(negedge clk);
      chk(cycle_a_n, 1'b0);
      wait_n = 1'b1;
      foreach (rows[k]) access(rows[k]);
      // One hidden refresh per slot, the second refused
      refresh_period_clock = 1'b1;
      @(negedge clk);
      hidden(9'h000, 4'h0);
      hidden(9'h000, 4'hF);
      refresh_period_clock = 1'b0;
      repeat (3) @(negedge clk);
      chk(pin, 1'b1);
      // An unused slot forces a refresh through the glue
      refresh_period_clock = 1'b1;
      repeat (4) @(negedge clk);
      refresh_period_clock = 1'b0;
      repeat (2) @(negedge clk);
      chk(pin, 1'b0);
      for (i = 0; i < 20 && dram.ras_n !== 4'h0; i++) @(negedge clk);
      chk(dram.ras_n, 4'h0);
      chk(cycle_a_n, 1'b1);
      for (i = 0; i < 20 && sel_n !== 1'b1; i++) @(negedge clk);
      repeat (8) @(negedge clk);
      chk({dram.ras_n, pin}, 5'h1F);
      access(rows[2]);
      refresh_period_clock = 1'b1;
      @(negedge clk);
      hidden(9'h002, 4'h0);
      report_and_stop();
   end
endmodule // drc_ctrl_tb_top
`default_nettype wire
